// *** testbench/tb.sv ***
// Self-checking bench for the torque limit and coincidence block
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int unsigned TICK = 4;
    logic clk_in, reset_in, rw, rr, ack, err, sel, coin, closed;
    logic [15:0] ra, wd, rdat, fwd_o, rev_o, lfsr_q;
    logic signed [15:0] act, tgt, cmd, cmd_o;
    logic [15:0] mreg [logic [15:0]];
    int errors, samples_checked;
    tqlc_top #(.MS_TICK_CYCLES(TICK)) tqlc_top_i (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(ra),
        .reg_wdata_in(wd), .reg_write_in(rw), .reg_read_in(rr), .reg_rdata_out(rdat), .reg_ack_out(ack),
        .reg_error_out(err), .actual_torque_in(act), .target_torque_in(tgt), .torque_command_in(cmd),
        .limit_select_input_in(sel), .torque_command_out(cmd_o), .forward_limit_out(fwd_o),
        .reverse_limit_out(rev_o), .torque_coincidence_out(coin), .coin_output_closed_out(closed));
    tqlc_host tqlc_host_i (.clk_in(clk_in), .reg_addr_out(ra), .reg_wdata_out(wd), .reg_write_out(rw),
        .reg_read_out(rr), .reg_rdata_in(rdat), .reg_ack_in(ack), .reg_error_in(err));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q;
    endfunction
    function automatic logic ok(input logic [15:0] a, input logic [15:0] d);
        if (!mreg.exists(a) || a == tqlc_pkg::ADDR_STATUS) return 1'b0;
        if (a == tqlc_pkg::ADDR_TIMER) return d <= tqlc_pkg::TIMER_MAX;
        if (a == tqlc_pkg::ADDR_METHOD) return d <= 16'h0003 || d == 16'h0005;
        if (a == tqlc_pkg::ADDR_DO_FUNC || a == tqlc_pkg::ADDR_SEL_POL) return 1'b1;
        return d <= tqlc_pkg::LIMIT_MAX;
    endfunction
    // Forward limit in the upper half, reverse in the lower
    function automatic logic [31:0] lim(input logic s);
        logic v, alt;
        logic [15:0] m, f;
        v = s ^ mreg[tqlc_pkg::ADDR_SEL_POL][0];
        m = mreg[tqlc_pkg::ADDR_METHOD];
        alt = (m == 16'h0003 || m == 16'h0005) && !v;
        f = m == 16'h0000 ? mreg[tqlc_pkg::ADDR_FWD_IMM] : !alt ? mreg[tqlc_pkg::ADDR_LIMIT1]
            : m == 16'h0003 ? mreg[tqlc_pkg::ADDR_LIMIT2] : mreg[tqlc_pkg::ADDR_LIMIT3];
        return {f, m == 16'h0000 ? mreg[tqlc_pkg::ADDR_REV_IMM] : (m == 16'h0001 || m == 16'h0003) ? f
            : alt ? mreg[tqlc_pkg::ADDR_LIMIT4] : mreg[tqlc_pkg::ADDR_LIMIT2]};
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
        logic [15:0] r;
        logic e, k, good;
        good = w ? ok(a, d) : mreg.exists(a);
        tqlc_host_i.access(w, a, d, int'(lfsr_q[0]), r, e, k);
        chk("ack", 16'h0001, {15'h0000, k});
        chk("error", {15'h0000, !good}, {15'h0000, e});
        if (!w) chk("rdata", good ? mreg[a] : 16'h0000, r);
        if (w && good) mreg[a] = d;
    endtask
    // Edges from a new deviation until coincidence, 64 if it never comes
    task automatic dwell(input logic signed [15:0] dv, output int n);
        logic signed [15:0] t;
        t = $signed(rnd()) >>> 4;
        @(posedge clk_in);
        tgt <= t;
        act <= t + dv;
        for (n = 1; n < 64; n++) begin
            @(posedge clk_in);
            #1;
            if (coin === 1'b1) break;
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // The run is well under a thousand cycles; this only catches a hang
    initial begin
        #500000;
        errors++;
        print_verdict();
    end
    initial begin
        logic [15:0] meth [5];
        logic [31:0] fr;
        int f, r, c, n;
        meth = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0005};
        errors = 0;
        samples_checked = 0;
        lfsr_q = 16'h0030;
        reset_in = 1'b1;
        act = 16'sh0000;
        tgt = 16'sh0000;
        cmd = 16'sh0000;
        sel = 1'b0;
        mreg[tqlc_pkg::ADDR_FWD_IMM] = tqlc_pkg::RST_IMM;
        mreg[tqlc_pkg::ADDR_REV_IMM] = tqlc_pkg::RST_IMM;
        mreg[tqlc_pkg::ADDR_TIMER] = tqlc_pkg::RST_TIMER;
        mreg[tqlc_pkg::ADDR_BAND] = tqlc_pkg::RST_BAND;
        mreg[tqlc_pkg::ADDR_METHOD] = tqlc_pkg::RST_METHOD;
        for (int j = 0; j < 4; j++) mreg[tqlc_pkg::ADDR_LIMIT1 + 16'(j)] = tqlc_pkg::RST_LIMIT;
        mreg[tqlc_pkg::ADDR_DO_FUNC] = tqlc_pkg::RST_DO_FUNC;
        mreg[tqlc_pkg::ADDR_SEL_POL] = tqlc_pkg::RST_SEL_POL;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        #1 chk("forward", tqlc_pkg::RST_LIMIT, fwd_o);
        chk("reverse", tqlc_pkg::RST_LIMIT, rev_o);
        foreach (mreg[a]) acc(1'b0, a, 16'h0000);
        acc(1'b0, 16'h0000, 16'h0000);
        acc(1'b1, tqlc_pkg::ADDR_STATUS, 16'h0001);
        acc(1'b1, tqlc_pkg::ADDR_METHOD, 16'h0004);
        acc(1'b1, tqlc_pkg::ADDR_LIMIT2, 16'h0bb9);
        acc(1'b1, tqlc_pkg::ADDR_FWD_IMM, 16'h0bb9);
        acc(1'b1, tqlc_pkg::ADDR_BAND, 16'h0bb9);
        acc(1'b1, tqlc_pkg::ADDR_TIMER, 16'h7531);
        acc(1'b1, tqlc_pkg::ADDR_TIMER, 16'h7530);
        for (int p = 0; p < 2; p++) begin
            acc(1'b1, tqlc_pkg::ADDR_SEL_POL, 16'(p));
            foreach (meth[i]) begin
                for (int j = 0; j < 6; j++) acc(1'b1, j < 2 ? tqlc_pkg::ADDR_FWD_IMM + 16'(j)
                    : tqlc_pkg::ADDR_LIMIT1 + 16'(j - 2), rnd() % 16'h0bb9);
                acc(1'b1, tqlc_pkg::ADDR_METHOD, meth[i]);
                for (int s = 0; s < 2; s++) begin
                    @(posedge clk_in);
                    sel <= s[0];
                    @(posedge clk_in);
                    cmd <= $signed(rnd()) >>> 3;
                    @(posedge clk_in);
                    #1 fr = lim(s[0]);
                    f = fr[31:16];
                    r = fr[15:0];
                    c = cmd;
                    chk("forward", 16'(f), fwd_o);
                    chk("reverse", 16'(r), rev_o);
                    chk("command", 16'(c > f ? f : c < -r ? -r : c), cmd_o);
                end
            end
        end
        acc(1'b1, tqlc_pkg::ADDR_BAND, 16'h000a);
        acc(1'b1, tqlc_pkg::ADDR_DO_FUNC, 16'h0023);
        for (int t = 0; t < 3; t += 2) begin
            acc(1'b1, tqlc_pkg::ADDR_TIMER, 16'(t));
            dwell(-16'sh000b, n);
            chk("dwell", 16'h0040, 16'(n));
            #10 chk("closed", 16'h0000, {15'h0000, closed});
            dwell(16'sh000a, n);
            chk("dwell", 16'(t * TICK + 1), 16'(n));
            #10 chk("closed", 16'h0001, {15'h0000, closed});
            // Coincident and in band; select last driven high under normally closed, so not valid
            mreg[tqlc_pkg::ADDR_STATUS] = 16'h0003;
            acc(1'b0, tqlc_pkg::ADDR_STATUS, 16'h0000);
        end
        dwell(16'sh0100, n);
        chk("dwell", 16'h0040, 16'(n));
        @(posedge clk_in);
        act <= tgt;
        repeat (6) @(posedge clk_in);
        act <= tgt + 16'sh0100;
        dwell(16'sh0000, n);
        chk("dwell", 16'(2 * TICK + 1), 16'(n));
        acc(1'b1, tqlc_pkg::ADDR_DO_FUNC, 16'h0024);
        #10 chk("closed", 16'h0000, {15'h0000, closed});
        dwell(-16'sh0100, n);
        chk("closed", 16'h0001, {15'h0000, closed});
        print_verdict();
    end
endmodule
`default_nettype wire

// *** testbench/tqlc_checker.sv ***
// Port-level assertions for the torque limit and coincidence block
`timescale 1ns/1ns
`default_nettype none
module tqlc_checker (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Register port
    input wire logic [15:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic reg_ack_out,
    input wire logic reg_error_out,
    // Torque path
    input wire logic signed [15:0] actual_torque_in,
    input wire logic signed [15:0] target_torque_in,
    input wire logic signed [15:0] torque_command_in,
    input wire logic signed [15:0] torque_command_out,
    input wire logic [15:0] forward_limit_out,
    input wire logic [15:0] reverse_limit_out,
    input wire logic torque_coincidence_out
);
    logic live_q;
    logic wide;
    logic signed [16:0] dev, fwd, rev, cmd_q;
    assign dev = 17'(actual_torque_in) - 17'(target_torque_in);
    // Beyond the widest band, so out of band whatever is programmed
    assign wide = (dev > 17'sh00bb8) || (dev < -17'sh00bb8);
    assign fwd = {1'b0, forward_limit_out};
    assign rev = {1'b0, reverse_limit_out};
    // Previous command; live_q masks the edge that still saw reset
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            live_q <= 1'b0;
            cmd_q <= 17'sh00000;
        end else begin
            live_q <= 1'b1;
            cmd_q <= 17'(torque_command_in);
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    property p_ack; (reg_read_in || reg_write_in) |=> reg_ack_out; endproperty
    a_ack: assert property (p_ack) else $error("no ack after strobe");
    property p_quiet; !(reg_read_in || reg_write_in) |=> !reg_ack_out && !reg_error_out; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without strobe");
    property p_meth; reg_write_in && reg_addr_in == tqlc_pkg::ADDR_METHOD && reg_wdata_in == 16'h0004 |=> reg_error_out; endproperty
    a_meth: assert property (p_meth) else $error("method 4 taken");
    property p_pass; live_q && cmd_q <= fwd && cmd_q >= -rev |-> 17'(torque_command_out) == cmd_q; endproperty
    a_pass: assert property (p_pass) else $error("command altered inside limits");
    property p_fwd; live_q && cmd_q > fwd |-> 17'(torque_command_out) == fwd; endproperty
    a_fwd: assert property (p_fwd) else $error("forward clamp wrong");
    property p_rev; live_q && cmd_q < -rev |-> 17'(torque_command_out) == -rev; endproperty
    a_rev: assert property (p_rev) else $error("reverse clamp wrong");
    property p_drop; wide |=> !torque_coincidence_out; endproperty
    a_drop: assert property (p_drop) else $error("coincidence kept out of band");
    property p_rise; $rose(torque_coincidence_out) |-> !$past(wide); endproperty
    a_rise: assert property (p_rise) else $error("coincidence rose out of band");
    c_rise: cover property ($rose(torque_coincidence_out));
    c_clamp: cover property (live_q && cmd_q > fwd);
    c_error: cover property (reg_error_out);
endmodule
bind tqlc_top tqlc_checker tqlc_checker_i (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_ack_out(reg_ack_out), .reg_error_out(reg_error_out), .actual_torque_in(actual_torque_in),
    .target_torque_in(target_torque_in), .torque_command_in(torque_command_in),
    .torque_command_out(torque_command_out), .forward_limit_out(forward_limit_out),
    .reverse_limit_out(reverse_limit_out), .torque_coincidence_out(torque_coincidence_out));
`default_nettype wire

// *** testbench/tqlc_host.sv ***
// Host controller model for the holding register port
`timescale 1ns/1ns
`default_nettype none
module tqlc_host (
    // Clock
    input wire logic clk_in,
    // Requests
    output logic [15:0] reg_addr_out,
    output logic [15:0] reg_wdata_out,
    output logic reg_write_out,
    output logic reg_read_out,
    // Answers
    input wire logic [15:0] reg_rdata_in,
    input wire logic reg_ack_in,
    input wire logic reg_error_in
);
    initial begin
        reg_addr_out = 16'h0000;
        reg_wdata_out = 16'h0000;
        reg_write_out = 1'b0;
        reg_read_out = 1'b0;
    end
    // One word per access; released lines show the inverse so stale values cannot pass
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d, input int gap,
        output logic [15:0] r, output logic e, output logic k);
        repeat (gap) @(posedge clk_in);
        @(posedge clk_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_write_out <= w;
        reg_read_out <= !w;
        @(posedge clk_in);
        reg_write_out <= 1'b0;
        reg_read_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~d;
        #1;
        k = reg_ack_in;
        e = reg_error_in;
        r = reg_rdata_in;
    endtask
endmodule
`default_nettype wire

// *** verilog/tqlc_coin_timer.sv ***
// Coincidence qualification timer with millisecond prescaler
`timescale 1ns/1ns
`default_nettype none
module tqlc_coin_timer #(
    parameter int unsigned TICK_CYCLES = tqlc_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Condition and setting
    input wire logic in_band_in,
    input wire logic [15:0] timer_ms_in,
    // Result
    output logic coin_out
);
    logic [tqlc_pkg::PRESC_W-1:0] presc_q;
    logic [tqlc_pkg::PRESC_W-1:0] presc_d;
    logic [15:0] ms_q;
    logic [15:0] ms_d;
    logic coin_q;
    // Last prescaler count of one millisecond, cut to the counter width
    localparam int unsigned TICK_LAST = TICK_CYCLES - 1;
    wire tick = presc_q == TICK_LAST[tqlc_pkg::PRESC_W-1:0];
    wire ms_full = ms_q == tqlc_pkg::TIMER_MAX;

    // Leaving the band restarts both counters
    assign presc_d = !in_band_in ? '0 : (tick ? '0 : presc_q + 1'b1);
    // Saturate so a long dwell never wraps and drops coincidence
    assign ms_d = !in_band_in ? 16'h0000 : ((tick && !ms_full) ? ms_q + 16'h0001 : ms_q);
    assign coin_out = coin_q;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            presc_q <= '0;
            ms_q <= 16'h0000;
            coin_q <= 1'b0;
        end else begin
            presc_q <= presc_d;
            ms_q <= ms_d;
            coin_q <= in_band_in && (ms_q >= timer_ms_in);
        end
    end
endmodule
`default_nettype wire

// *** verilog/tqlc_pkg.sv ***
// Constants for the torque limit and coincidence block
package tqlc_pkg;
    // Holding register addresses (immediate limits as printed)
    localparam logic [15:0] ADDR_FWD_IMM = 16'h9c81;
    localparam logic [15:0] ADDR_REV_IMM = 16'h9c82;
    // Parameter register addresses
    localparam logic [15:0] ADDR_TIMER = 16'h9d00;
    localparam logic [15:0] ADDR_BAND = 16'h9d01;
    localparam logic [15:0] ADDR_METHOD = 16'h9d02;
    localparam logic [15:0] ADDR_LIMIT1 = 16'h9d03;
    localparam logic [15:0] ADDR_LIMIT2 = 16'h9d04;
    localparam logic [15:0] ADDR_LIMIT3 = 16'h9d05;
    localparam logic [15:0] ADDR_LIMIT4 = 16'h9d06;
    localparam logic [15:0] ADDR_DO_FUNC = 16'h9d07;
    localparam logic [15:0] ADDR_SEL_POL = 16'h9d08;
    localparam logic [15:0] ADDR_STATUS = 16'h9d09;

    // Reset values
    localparam logic [15:0] RST_IMM = 16'h0000;
    localparam logic [15:0] RST_TIMER = 16'h000a;
    localparam logic [15:0] RST_BAND = 16'h000a;
    localparam logic [15:0] RST_METHOD = 16'h0001;
    localparam logic [15:0] RST_LIMIT = 16'h0bb8;
    localparam logic [15:0] RST_DO_FUNC = 16'h0000;
    localparam logic [15:0] RST_SEL_POL = 16'h0000;

    // Value ranges
    localparam logic [15:0] LIMIT_MAX = 16'h0bb8;
    localparam logic [15:0] BAND_MAX = 16'h0bb8;
    localparam logic [15:0] TIMER_MAX = 16'h7530;

    // Limit methods
    localparam logic [15:0] METHOD_IMM = 16'h0000;
    localparam logic [15:0] METHOD_ONE = 16'h0001;
    localparam logic [15:0] METHOD_SPLIT = 16'h0002;
    localparam logic [15:0] METHOD_SEL_SAME = 16'h0003;
    localparam logic [15:0] METHOD_SEL_SPLIT = 16'h0005;

    // Digital output function codes
    localparam logic [15:0] DO_COIN_NO = 16'h0023;
    localparam logic [15:0] DO_COIN_NC = 16'h0024;

    // Status register fields
    localparam int STAT_COIN_BIT = 0;
    localparam int STAT_INBAND_BIT = 1;
    localparam int STAT_SEL_BIT = 2;

    // Timing: one millisecond of timer resolution
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int PRESC_W = 17;
endpackage

// *** verilog/tqlc_top.sv ***
// Torque coincidence detector and torque limit source selector
`timescale 1ns/1ns
`default_nettype none
module tqlc_top #(
    parameter int unsigned MS_TICK_CYCLES = tqlc_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Holding register port
    input wire logic [15:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_ack_out,
    output logic reg_error_out,
    // Torque inputs, signed, 0.1 percent units
    input wire logic signed [15:0] actual_torque_in,
    input wire logic signed [15:0] target_torque_in,
    input wire logic signed [15:0] torque_command_in,
    // Limit select digital input
    input wire logic limit_select_input_in,
    // Limited torque and active limits
    output logic signed [15:0] torque_command_out,
    output logic [15:0] forward_limit_out,
    output logic [15:0] reverse_limit_out,
    // Coincidence indication and its digital output
    output logic torque_coincidence_out,
    output logic coin_output_closed_out
);
    // Register storage
    logic [15:0] forward_limit_immediate_q;
    logic [15:0] reverse_limit_immediate_q;
    logic [15:0] coincidence_timer_ms_q;
    logic [15:0] torque_band_tolerance_q;
    logic [15:0] limit_method_select_q;
    logic [15:0] limit_value_one_q;
    logic [15:0] limit_value_two_q;
    logic [15:0] limit_value_three_q;
    logic [15:0] limit_value_four_q;
    logic [15:0] do_function_q;
    logic select_nc_q;

    // Bus answer registers
    logic [15:0] rdata_q;
    logic ack_q;
    logic error_q;

    // Output registers
    logic signed [15:0] cmd_q;
    logic [15:0] fwd_q;
    logic [15:0] rev_q;
    logic closed_q;
    logic coin;

    // Address decode
    wire hit_fwd_imm = reg_addr_in == tqlc_pkg::ADDR_FWD_IMM;
    wire hit_rev_imm = reg_addr_in == tqlc_pkg::ADDR_REV_IMM;
    wire hit_timer = reg_addr_in == tqlc_pkg::ADDR_TIMER;
    wire hit_band = reg_addr_in == tqlc_pkg::ADDR_BAND;
    wire hit_method = reg_addr_in == tqlc_pkg::ADDR_METHOD;
    wire hit_lim1 = reg_addr_in == tqlc_pkg::ADDR_LIMIT1;
    wire hit_lim2 = reg_addr_in == tqlc_pkg::ADDR_LIMIT2;
    wire hit_lim3 = reg_addr_in == tqlc_pkg::ADDR_LIMIT3;
    wire hit_lim4 = reg_addr_in == tqlc_pkg::ADDR_LIMIT4;
    wire hit_do = reg_addr_in == tqlc_pkg::ADDR_DO_FUNC;
    wire hit_pol = reg_addr_in == tqlc_pkg::ADDR_SEL_POL;
    wire hit_stat = reg_addr_in == tqlc_pkg::ADDR_STATUS;
    wire hit_limit_reg = hit_fwd_imm | hit_rev_imm | hit_lim1 | hit_lim2 | hit_lim3 | hit_lim4;
    wire mapped = hit_limit_reg | hit_timer | hit_band | hit_method | hit_do | hit_pol | hit_stat;

    // Range checks; an out-of-range write is refused and the old value kept
    wire limit_ok = reg_wdata_in <= tqlc_pkg::LIMIT_MAX;
    wire timer_ok = reg_wdata_in <= tqlc_pkg::TIMER_MAX;
    wire band_ok = reg_wdata_in <= tqlc_pkg::BAND_MAX;
    wire method_ok = (reg_wdata_in <= tqlc_pkg::METHOD_SEL_SAME) ||
                     (reg_wdata_in == tqlc_pkg::METHOD_SEL_SPLIT);
    wire value_ok = (hit_limit_reg & limit_ok) | (hit_timer & timer_ok) | (hit_band & band_ok) |
                    (hit_method & method_ok) | hit_do | hit_pol;
    wire wr_ok = reg_write_in & value_ok;
    wire wr_bad = reg_write_in & !value_ok;
    wire rd_bad = reg_read_in & !mapped;

    // Coincidence band check on signed deviation
    wire signed [16:0] deviation = 17'(actual_torque_in) - 17'(target_torque_in);
    wire [16:0] deviation_abs = deviation[16] ? 17'(-deviation) : 17'(deviation);
    wire in_band = deviation_abs <= {1'b0, torque_band_tolerance_q};

    // Select input active level, normally open or normally closed
    wire select_valid = limit_select_input_in ^ select_nc_q;

    // Limit source selection
    logic [15:0] fwd_sel;
    logic [15:0] rev_sel;
    always_comb begin
        fwd_sel = limit_value_one_q;
        rev_sel = limit_value_one_q;
        if (limit_method_select_q == tqlc_pkg::METHOD_IMM) begin
            fwd_sel = forward_limit_immediate_q;
            rev_sel = reverse_limit_immediate_q;
        end else if (limit_method_select_q == tqlc_pkg::METHOD_SPLIT) begin
            fwd_sel = limit_value_one_q;
            rev_sel = limit_value_two_q;
        end else if (limit_method_select_q == tqlc_pkg::METHOD_SEL_SAME) begin
            fwd_sel = select_valid ? limit_value_one_q : limit_value_two_q;
            rev_sel = fwd_sel;
        end else if (limit_method_select_q == tqlc_pkg::METHOD_SEL_SPLIT) begin
            fwd_sel = select_valid ? limit_value_one_q : limit_value_three_q;
            rev_sel = select_valid ? limit_value_two_q : limit_value_four_q;
        end
    end

    // Clamp, independent of control mode, re-evaluated every clock
    wire signed [16:0] cmd_wide = 17'(torque_command_in);
    wire signed [16:0] fwd_wide = $signed({1'b0, fwd_sel});
    wire signed [16:0] rev_neg = 17'(-$signed({1'b0, rev_sel}));
    wire signed [16:0] cmd_clamped = (cmd_wide > fwd_wide) ? fwd_wide :
                                     ((cmd_wide < rev_neg) ? rev_neg : cmd_wide);

    // Digital output state from assigned function code
    wire closed_d = (do_function_q == tqlc_pkg::DO_COIN_NO) ? coin :
                    ((do_function_q == tqlc_pkg::DO_COIN_NC) ? !coin : 1'b0);

    // Status word of live block state
    wire [15:0] status_word = 16'(({15'h0000, coin} << tqlc_pkg::STAT_COIN_BIT) |
                                  ({15'h0000, in_band} << tqlc_pkg::STAT_INBAND_BIT) |
                                  ({15'h0000, select_valid} << tqlc_pkg::STAT_SEL_BIT));

    // Read selection
    wire [15:0] rd_mux = hit_fwd_imm ? forward_limit_immediate_q :
                         hit_rev_imm ? reverse_limit_immediate_q :
                         hit_timer ? coincidence_timer_ms_q :
                         hit_band ? torque_band_tolerance_q :
                         hit_method ? limit_method_select_q :
                         hit_lim1 ? limit_value_one_q :
                         hit_lim2 ? limit_value_two_q :
                         hit_lim3 ? limit_value_three_q :
                         hit_lim4 ? limit_value_four_q :
                         hit_do ? do_function_q :
                         hit_pol ? {15'h0000, select_nc_q} :
                         hit_stat ? status_word : 16'h0000;

    tqlc_coin_timer #(
        .TICK_CYCLES(MS_TICK_CYCLES)
    ) u_coin_timer (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .in_band_in(in_band),
        .timer_ms_in(coincidence_timer_ms_q),
        .coin_out(coin)
    );

    // Register writes take effect on the next clock
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            forward_limit_immediate_q <= tqlc_pkg::RST_IMM;
            reverse_limit_immediate_q <= tqlc_pkg::RST_IMM;
            coincidence_timer_ms_q <= tqlc_pkg::RST_TIMER;
            torque_band_tolerance_q <= tqlc_pkg::RST_BAND;
            limit_method_select_q <= tqlc_pkg::RST_METHOD;
            limit_value_one_q <= tqlc_pkg::RST_LIMIT;
            limit_value_two_q <= tqlc_pkg::RST_LIMIT;
            limit_value_three_q <= tqlc_pkg::RST_LIMIT;
            limit_value_four_q <= tqlc_pkg::RST_LIMIT;
            do_function_q <= tqlc_pkg::RST_DO_FUNC;
            select_nc_q <= tqlc_pkg::RST_SEL_POL[0];
        end else if (wr_ok) begin
            if (hit_fwd_imm) begin
                forward_limit_immediate_q <= reg_wdata_in;
            end
            if (hit_rev_imm) begin
                reverse_limit_immediate_q <= reg_wdata_in;
            end
            if (hit_timer) begin
                coincidence_timer_ms_q <= reg_wdata_in;
            end
            if (hit_band) begin
                torque_band_tolerance_q <= reg_wdata_in;
            end
            if (hit_method) begin
                limit_method_select_q <= reg_wdata_in;
            end
            if (hit_lim1) begin
                limit_value_one_q <= reg_wdata_in;
            end
            if (hit_lim2) begin
                limit_value_two_q <= reg_wdata_in;
            end
            if (hit_lim3) begin
                limit_value_three_q <= reg_wdata_in;
            end
            if (hit_lim4) begin
                limit_value_four_q <= reg_wdata_in;
            end
            if (hit_do) begin
                do_function_q <= reg_wdata_in;
            end
            if (hit_pol) begin
                select_nc_q <= reg_wdata_in[0];
            end
        end
    end

    // Bus answer: one-cycle acknowledge after any strobe
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_q <= 16'h0000;
            ack_q <= 1'b0;
            error_q <= 1'b0;
        end else begin
            rdata_q <= reg_read_in ? rd_mux : 16'h0000;
            ack_q <= reg_read_in | reg_write_in;
            error_q <= rd_bad | wr_bad;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cmd_q <= 16'sh0000;
            fwd_q <= 16'h0000;
            rev_q <= 16'h0000;
            closed_q <= 1'b0;
        end else begin
            cmd_q <= cmd_clamped[15:0];
            fwd_q <= fwd_sel;
            rev_q <= rev_sel;
            closed_q <= closed_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reg_ack_out = ack_q;
    assign reg_error_out = error_q;
    assign torque_command_out = cmd_q;
    assign forward_limit_out = fwd_q;
    assign reverse_limit_out = rev_q;
    assign torque_coincidence_out = coin;
    assign coin_output_closed_out = closed_q;
endmodule
`default_nettype wire
